// *** scr_pkg.sv ***
package scr_pkg;

    // ----------------------------------------
    // target interface
    // ----------------------------------------
    localparam logic [6:0] SCR_DEV_ADDR   = 7'h3C;
    localparam logic [7:0] SCR_REC_OFFSET = 8'h0C;
    localparam logic [7:0] SCR_UNMAPPED   = 8'h00;

    // ----------------------------------------
    // recorder layout
    // ----------------------------------------
    localparam logic [7:0] SCR_REC_RESET  = 8'h40;
    localparam int SCR_RESET_INPUT_BIT    = 7;
    localparam int SCR_BATT_UNDER_BIT     = 6;
    localparam int SCR_BATT_OVER_BIT      = 5;
    localparam int SCR_BATT_LOW_BIT       = 4;
    localparam int SCR_THERMAL_BIT        = 3;
    localparam int SCR_HARD_RESET_BIT     = 2;
    localparam int SCR_WATCHDOG_BIT       = 1;
    localparam int SCR_SHUTDOWN_PIN_CAUSE_PIN_BIT       = 0;

    typedef enum logic [2:0] {
        SCR_IDLE,
        SCR_ADDR,
        SCR_ACK_ADDR,
        SCR_REG,
        SCR_ACK_DATA,
        SCR_WDATA,
        SCR_TX,
        SCR_RACK
    } scr_state_t;

endpackage

// *** scr_rec_if.sv ***
`timescale 1ns/10ps
interface scr_rec_if;
    logic       rd_strobe;
    logic [7:0] rd_data;
    modport target   (output rd_strobe, input  rd_data);
    modport recorder (input  rd_strobe, output rd_data);
endinterface

// *** scr_recorder.sv ***
`timescale 1ns/10ps
module scr_recorder
    import scr_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       shutdown_event,
    input  wire logic [7:0] causes,
    scr_rec_if.recorder     bus
);

    // ----------------------------------------
    // flag storage
    // ----------------------------------------
    logic [7:0] flags;
    wire  [7:0] cleared    = bus.rd_strobe ? 8'h00 : flags;
    // set wins over the clearing read so no cause is lost
    wire  [7:0] next_flags = cleared | (shutdown_event ? causes : 8'h00);

    // sys_rst stands for backup supply collapse; shutdown only ORs its causes into the flags
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            flags <= SCR_REC_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    assign bus.rd_data = flags;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_read_clears: assert property (@(posedge core_clk) disable iff (sys_rst)
        bus.rd_strobe && !shutdown_event |=> flags == 8'h00)
        else $error("read did not clear recorder");
    chk_flags_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        !bus.rd_strobe && !shutdown_event |=> $stable(flags))
        else $error("recorder changed without cause");
    chk_reset_input_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        shutdown_event && causes[SCR_RESET_INPUT_BIT] |=> flags[SCR_RESET_INPUT_BIT])
        else $error("reset input cause not recorded");
    chk_batt_under_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        shutdown_event && causes[SCR_BATT_UNDER_BIT] |=> flags[SCR_BATT_UNDER_BIT])
        else $error("undervoltage cause not recorded");
    chk_batt_over_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        shutdown_event && causes[SCR_BATT_OVER_BIT] |=> flags[SCR_BATT_OVER_BIT])
        else $error("overvoltage cause not recorded");
    chk_batt_low_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        shutdown_event && causes[SCR_BATT_LOW_BIT] |=> flags[SCR_BATT_LOW_BIT])
        else $error("battery low cause not recorded");
    chk_thermal_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        shutdown_event && causes[SCR_THERMAL_BIT] |=> flags[SCR_THERMAL_BIT])
        else $error("thermal cause not recorded");
    chk_hard_reset_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        shutdown_event && causes[SCR_HARD_RESET_BIT] |=> flags[SCR_HARD_RESET_BIT])
        else $error("hard reset cause not recorded");
    chk_watchdog_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        shutdown_event && causes[SCR_WATCHDOG_BIT] |=> flags[SCR_WATCHDOG_BIT])
        else $error("watchdog cause not recorded");
    chk_shutdown_pin_cause_pin_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        shutdown_event && causes[SCR_SHUTDOWN_PIN_CAUSE_PIN_BIT] |=> flags[SCR_SHUTDOWN_PIN_CAUSE_PIN_BIT])
        else $error("shutdown pin cause not recorded");

endmodule

// *** scr_top.sv ***
`timescale 1ns/10ps
// Contract
// - reset input shutdown sets bit 7, else stays clear.
// - battery undervoltage shutdown sets bit 6.
// - battery overvoltage shutdown sets bit 5.
// - battery low shutdown with powerdown enabled sets bit 4.
// - thermal overload shutdown sets bit 3.
// - hard reset shutdown sets bit 2, else stays clear.
// - system watchdog expiry shutdown sets bit 1.
// - shutdown pin shutdown sets bit 0.
module scr_top
    import scr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = SCR_DEV_ADDR
)(
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output wire logic sda_out,
    output wire logic sda_oe,
    input  wire logic global_shutdown,
    input  wire logic reset_input_signal,
    input  wire logic battery_undervoltage,
    input  wire logic battery_overvoltage,
    input  wire logic battery_low,
    input  wire logic low_battery_powerdown_enable,
    input  wire logic thermal_overload,
    input  wire logic hard_reset,
    input  wire logic watchdog_expired,
    input  wire logic shutdown_pin
);

    // refused at elaboration: address zero would answer every general call
    if (DEV_ADDR == 7'h00) begin
        $error("general call address cannot serve as target address");
    end


    // ----------------------------------------
    // cause collection
    // ----------------------------------------
    wire [7:0] causes;
    assign causes[SCR_RESET_INPUT_BIT] = reset_input_signal;
    assign causes[SCR_BATT_UNDER_BIT]  = battery_undervoltage;
    assign causes[SCR_BATT_OVER_BIT]   = battery_overvoltage;
    // a low monitor only counts when the powerdown is enabled
    assign causes[SCR_BATT_LOW_BIT]    = battery_low & low_battery_powerdown_enable;
    assign causes[SCR_THERMAL_BIT]     = thermal_overload;
    assign causes[SCR_HARD_RESET_BIT]  = hard_reset;
    assign causes[SCR_WATCHDOG_BIT]    = watchdog_expired;
    assign causes[SCR_SHUTDOWN_PIN_CAUSE_PIN_BIT]    = shutdown_pin;

    scr_rec_if rec_bus ();

    scr_recorder u_rec (
        .core_clk       (core_clk),
        .sys_rst        (sys_rst),
        .shutdown_event (global_shutdown),
        .causes         (causes),
        .bus            (rec_bus.recorder)
    );

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic       scl_f;
    logic       sda_f;
    logic       scl_p;
    logic       sda_p;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
        end
    end

    // level moves only when the second and third stages agree
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_f <= (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_f;
            sda_f <= (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_f;
            scl_p <= scl_f;
            sda_p <= sda_f;
        end
    end

    wire scl_rise = scl_f & ~scl_p;
    wire scl_fall = ~scl_f & scl_p;
    wire bus_start = scl_f & scl_p & sda_p & ~sda_f;
    wire bus_stop  = scl_f & scl_p & ~sda_p & sda_f;

    // ----------------------------------------
    // target state machine
    // ----------------------------------------
    scr_state_t state;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic [3:0] bitcnt;
    logic       rw;
    logic       got_ack;
    logic       drive_low;

    wire byte_done = (bitcnt == 4'h8);
    wire addr_hit  = (shreg[7:1] == DEV_ADDR);
    wire load_now  = scl_fall & (((state == SCR_ACK_ADDR) & rw) | ((state == SCR_RACK) & got_ack));
    wire rec_sel   = (ptr == SCR_REC_OFFSET);
    wire [7:0] rd_byte = rec_sel ? rec_bus.rd_data : SCR_UNMAPPED;
    wire receiving = (state == SCR_ADDR) | (state == SCR_REG) | (state == SCR_WDATA);

    // fetching the byte is what clears it, so a nacked byte is still lost
    assign rec_bus.rd_strobe = load_now & rec_sel;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state     <= SCR_IDLE;
            shreg     <= 8'h00;
            tx        <= 8'h00;
            ptr       <= 8'h00;
            bitcnt    <= 4'h0;
            rw        <= 1'b0;
            got_ack   <= 1'b0;
            drive_low <= 1'b0;
        end else if (bus_start) begin
            state     <= SCR_ADDR;
            bitcnt    <= 4'h0;
            drive_low <= 1'b0;
        end else if (bus_stop) begin
            state     <= SCR_IDLE;
            drive_low <= 1'b0;
        end else if (scl_rise) begin
            if (receiving) begin
                shreg  <= {shreg[6:0], sda_f};
                bitcnt <= 4'(bitcnt + 4'h1);
            end else if (state == SCR_RACK) begin
                got_ack <= ~sda_f;
            end
        end else if (scl_fall) begin
            case (state)
                SCR_ADDR: begin
                    if (byte_done) begin
                        state     <= addr_hit ? SCR_ACK_ADDR : SCR_IDLE;
                        rw        <= shreg[0];
                        drive_low <= addr_hit;
                    end
                end
                SCR_REG, SCR_WDATA: begin
                    if (byte_done) begin
                        // writes are acked but dropped: the recorder is read-only
                        if (state == SCR_REG) begin
                            ptr <= shreg;
                        end
                        state     <= SCR_ACK_DATA;
                        drive_low <= 1'b1;
                    end
                end
                SCR_ACK_ADDR, SCR_RACK: begin
                    bitcnt <= 4'h1;
                    if (load_now) begin
                        state     <= SCR_TX;
                        tx        <= {rd_byte[6:0], 1'b1};
                        drive_low <= ~rd_byte[7];
                        ptr       <= 8'(ptr + 8'h01);
                    end else begin
                        state     <= (state == SCR_RACK) ? SCR_IDLE : SCR_REG;
                        bitcnt    <= 4'h0;
                        drive_low <= 1'b0;
                    end
                end
                SCR_ACK_DATA: begin
                    state     <= SCR_WDATA;
                    bitcnt    <= 4'h0;
                    drive_low <= 1'b0;
                end
                SCR_TX: begin
                    if (byte_done) begin
                        state     <= SCR_RACK;
                        drive_low <= 1'b0;
                    end else begin
                        tx        <= {tx[6:0], 1'b1};
                        drive_low <= ~tx[7];
                        bitcnt    <= 4'(bitcnt + 4'h1);
                    end
                end
                default: begin
                    drive_low <= 1'b0;
                end
            endcase
        end
    end

    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe  = drive_low;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_clear_only_rec: assert property (@(posedge core_clk) disable iff (sys_rst)
        rec_bus.rd_strobe |-> ptr == SCR_REC_OFFSET && scl_fall)
        else $error("recorder cleared by access to another offset");
    chk_tx_first_bit: assert property (@(posedge core_clk) disable iff (sys_rst)
        load_now && !bus_start && !bus_stop |=> state == SCR_TX && sda_oe == ~$past(rd_byte[7]))
        else $error("first read bit not driven from recorder");

endmodule

// *** scr_host_model.sv ***
`timescale 1ns/10ps
module scr_host_model
    import scr_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_rel
);
    // ----------------------------------------
    // bit level
    // ----------------------------------------
    // half period in core clocks, raised by the bench for a slow host
    int         half = 10;
    logic [7:0] saved_cause;

    initial begin
        scl_out = 1'b1;
        sda_rel = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // data changes only while scl is low, sampled mid high phase
    task automatic bit_io(input logic b, output logic s);
        sda_rel <= b;
        wt(half / 2);
        scl_out <= 1'b1;
        wt(half / 2);
        s = sda_in;
        wt(half / 2);
        scl_out <= 1'b0;
        wt(half / 2);
    endtask

    // serves plain and repeated start alike
    task automatic start_cond();
        sda_rel <= 1'b1;
        wt(half / 2);
        scl_out <= 1'b1;
        wt(half / 2);
        sda_rel <= 1'b0;
        wt(half / 2);
        scl_out <= 1'b0;
        wt(half / 2);
    endtask

    task automatic stop_cond();
        sda_rel <= 1'b0;
        wt(half / 2);
        scl_out <= 1'b1;
        wt(half / 2);
        sda_rel <= 1'b1;
        wt(half);
    endtask

    // ninth bit is always released: ack sampled on writes, nack given on reads
    task automatic byte_io(input logic [7:0] b, output logic [7:0] r, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
            r[i] = s;
        end
        bit_io(1'b1, ack_n);
    endtask

    // ----------------------------------------
    // transfers
    // ----------------------------------------
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] data,
                            output logic [2:0] nacks);
        logic [7:0] r;
        logic       a;
        start_cond();
        byte_io({dev, 1'b0}, r, nacks[2]);
        byte_io(ptr, r, nacks[1]);
        start_cond();
        byte_io({dev, 1'b1}, r, nacks[0]);
        byte_io(8'hFF, data, a);
        stop_cond();
        // the read clears the flags, so keep a copy
        if (ptr == SCR_REC_OFFSET) begin
            saved_cause = data;
        end
    endtask

    // master acks the first byte so the target goes on to the next register
    task automatic read_pair(input logic [7:0] ptr, output logic [15:0] data, output logic [2:0] nacks);
        logic [7:0] r;
        logic       s;
        logic       a;
        start_cond();
        byte_io({SCR_DEV_ADDR, 1'b0}, r, nacks[2]);
        byte_io(ptr, r, nacks[1]);
        start_cond();
        byte_io({SCR_DEV_ADDR, 1'b1}, r, nacks[0]);
        for (int i = 15; i >= 8; i--) begin
            bit_io(1'b1, s);
            data[i] = s;
        end
        bit_io(1'b0, s);
        byte_io(8'hFF, r, a);
        data[7:0] = r;
        stop_cond();
    endtask

    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] wdat, output logic [2:0] nacks);
        logic [7:0] r;
        start_cond();
        byte_io({SCR_DEV_ADDR, 1'b0}, r, nacks[2]);
        byte_io(ptr, r, nacks[1]);
        byte_io(wdat, r, nacks[0]);
        stop_cond();
    endtask
endmodule

// *** scr_top_test.sv ***
`timescale 1ns/10ps
module scr_top_test
    import scr_pkg::*;
();
    logic       core_clk;
    logic       sys_rst;
    logic       global_shutdown;
    logic [7:0] cause_v;
    logic       lbp_en;
    logic       scl_w;
    logic       sda_rel;
    logic       sda_out;
    logic       sda_oe;
    wire logic  sda_w;
    int         err_count;
    int         num_checks;
    logic [7:0] rd;
    logic [2:0] nk;
    logic [15:0] pair;

    // ----------------------------------------
    // wiring
    // ----------------------------------------
    // pull-up: high unless someone pulls low
    assign sda_w = sda_rel & (sda_out | ~sda_oe);

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    scr_top i_scr_top (
        .core_clk                     (core_clk),
        .sys_rst                      (sys_rst),
        .scl_in                       (scl_w),
        .sda_in                       (sda_w),
        .sda_out                      (sda_out),
        .sda_oe                       (sda_oe),
        .global_shutdown              (global_shutdown),
        .reset_input_signal           (cause_v[7]),
        .battery_undervoltage         (cause_v[6]),
        .battery_overvoltage          (cause_v[5]),
        .battery_low                  (cause_v[4]),
        .low_battery_powerdown_enable (lbp_en),
        .thermal_overload             (cause_v[3]),
        .hard_reset                   (cause_v[2]),
        .watchdog_expired             (cause_v[1]),
        .shutdown_pin                 (cause_v[0])
    );

    scr_host_model i_scr_host_model (
        .core_clk (core_clk),
        .sda_in   (sda_w),
        .scl_out  (scl_w),
        .sda_rel  (sda_rel)
    );

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    task automatic read_chk(input logic [7:0] ptr, input logic [7:0] exp);
        i_scr_host_model.read_reg(SCR_DEV_ADDR, ptr, rd, nk);
        check("read_acks", 8'h00, {5'h00, nk});
        check("read_data", exp, rd);
    endtask

    task automatic shut(input logic [7:0] c, input logic en);
        cause_v <= c;
        lbp_en <= en;
        global_shutdown <= 1'b1;
        @(posedge core_clk);
        global_shutdown <= 1'b0;
        cause_v <= 8'h00;
        @(posedge core_clk);
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (100000) @(posedge core_clk);
        $display("[ERR] run_length expected end seen hang");
        err_count++;
        finish_test();
    end

    initial begin
        sys_rst = 1'b1;
        global_shutdown = 1'b0;
        cause_v = 8'h00;
        lbp_en = 1'b0;
        err_count = 0;
        num_checks = 0;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        // pins need a few cycles through the synchroniser
        repeat (4) @(posedge core_clk);
        read_chk(SCR_REC_OFFSET, SCR_REC_RESET);
        read_chk(SCR_REC_OFFSET, 8'h00);
        for (int i = 0; i < 8; i++) begin
            shut(8'h01 << i, 1'b1);
            read_chk(SCR_REC_OFFSET, 8'h01 << i);
        end
        // causes present without a shutdown leave nothing behind
        cause_v <= 8'hFF;
        repeat (3) @(posedge core_clk);
        cause_v <= 8'h00;
        read_chk(SCR_REC_OFFSET, 8'h00);
        shut(8'h10, 1'b0);
        read_chk(SCR_REC_OFFSET, 8'h00);
        shut(8'h84, 1'b1);
        shut(8'h02, 1'b1);
        read_chk(SCR_REC_OFFSET, 8'h86);
        shut(8'h21, 1'b1);
        i_scr_host_model.write_reg(SCR_REC_OFFSET, 8'hDE, nk);
        check("write_acks", 8'h00, {5'h00, nk});
        read_chk(SCR_REC_OFFSET, 8'h21);
        shut(8'h08, 1'b1);
        read_chk(SCR_UNMAPPED, 8'h00);
        read_chk(SCR_REC_OFFSET, 8'h08);
        shut(8'h18, 1'b1);
        // master ack moves the pointer on, so the second byte comes from the recorder
        i_scr_host_model.read_pair(SCR_REC_OFFSET - 8'h01, pair, nk);
        check("pair_acks", 8'h00, {5'h00, nk});
        check("pair_first", SCR_UNMAPPED, pair[15:8]);
        check("pair_second", 8'h18, pair[7:0]);
        read_chk(SCR_REC_OFFSET, 8'h00);
        i_scr_host_model.read_reg(SCR_DEV_ADDR ^ 7'h01, SCR_REC_OFFSET, rd, nk);
        check("foreign_addr_nack", 8'h01, {7'h00, nk[2]});
        i_scr_host_model.half = 40;
        shut(8'h40, 1'b1);
        read_chk(SCR_REC_OFFSET, 8'h40);
        i_scr_host_model.half = 10;
        // backup supply collapse in mid run
        shut(8'h03, 1'b1);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        read_chk(SCR_REC_OFFSET, SCR_REC_RESET);
        check("saved_cause", SCR_REC_RESET, i_scr_host_model.saved_cause);
        finish_test();
    end
endmodule
